// ---- core/sdtx_core.sv ----
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "sdtx_regs.svh"
// Contract
// - With filtering on, characters 000 to 003 become 000 and 3FC to 3FF become 3FF before coding.
// - In SDI mode each filtered 10-bit character is scrambled and NRZI-coded onto the ten outputs with load enable held low.
// - Protocol select low picks the ASI mode, which bypasses both scrambler and NRZI coder.
// - In ASI mode the character passes the FIFO uncoded; load enable goes low when its load_now_n or the previous character's load_next_n is low.
// - In ASI mode the byte sits on output bits 1 to 8, the violation select on bit 9 and the special select on bit 0.
// - The scrambler is self-synchronizing with feedback taps of x^9 + x^4 + 1.
// - The NRZI stage is x + 1: a scrambled one toggles the line level and a zero holds it.
// - Each character is scrambled least significant bit first, in ascending order.
// - With the filter control high every character reaches the scrambler unmodified.
module sdtx_core import sdtx_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Character source
	input wire sdtx_char_t src_char,
	input wire logic src_valid,
	output logic src_ready,
	// Serializer side
	output logic [9:0] enc_q,
	output logic load_enable_out,
	output logic enc_valid,
	input wire logic enc_ready
);
	// Scrambles and NRZI-codes one character, bit 0 first
	function automatic sdtx_scr_t scramble(input logic [9:0] d, input logic [8:0] s, input logic line);
		sdtx_scr_t r;
		logic sc;
		r.lfsr = s;
		r.line = line;
		r.q = '0;
		for (int i = 0; i < `SDTX_CHAR_BITS; i++) begin
			sc = d[i] ^ r.lfsr[8] ^ r.lfsr[3];
			r.lfsr = {r.lfsr[7:0], sc};
			r.line = r.line ^ sc;
			r.q[i] = r.line;
		end
		return r;
	endfunction : scramble

	// Folds the reserved code ranges onto the reference codes
	function automatic logic [9:0] filter_code(input logic [9:0] d, input logic filter_n);
		logic [9:0] r;
		r = d;
		if (!filter_n) begin
			if (d <= `SDTX_LOW_CODE_MAX) begin
				r = `SDTX_LOW_CODE;
			end else if (d >= `SDTX_HIGH_CODE_MIN) begin
				r = `SDTX_HIGH_CODE;
			end
		end
		return r;
	endfunction : filter_code

	// Control state
	logic sdi_mode;
	logic code_filter_n;
	logic [8:0] lfsr;
	logic line;
	logic next_pending;
	logic [15:0] char_count;

	// FIFO drain side
	sdtx_char_t fifo_char;
	logic fifo_valid;
	logic [4:0] fifo_level;

	// A stalled serializer holds the output, which backs up into the FIFO and the source
	wire stage_free = !enc_valid || enc_ready;
	wire take = fifo_valid && stage_free;

	sdtx_fifo #(
		.WIDTH($bits(sdtx_char_t)),
		.DEPTH(`SDTX_FIFO_DEPTH)
	) sdtx_fifo_inst (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(src_valid),
		.in_ready(src_ready),
		.in_data(src_char),
		.out_valid(fifo_valid),
		.out_ready(stage_free),
		.out_data(fifo_char),
		.level(fifo_level)
	);

	// SDI path
	wire [9:0] filtered = filter_code(fifo_char.data, code_filter_n);
	wire sdtx_scr_t scr = scramble(filtered, lfsr, line);

	// ASI path: byte on 8..1, violation on 9, special on 0
	wire [9:0] asi_q = {fifo_char.violation_symbol_select, fifo_char.data[7:0],
		fifo_char.special_char_select};
	wire asi_load = fifo_char.load_now_n && !next_pending;

	wire [9:0] next_q = sdi_mode ? scr.q : asi_q;
	wire next_load = sdi_mode ? 1'b0 : asi_load;

	// APB decode
	wire apb_wr = psel && penable && pwrite;
	wire hit_ctrl = (paddr == `SDTX_OFF_CTRL);
	wire hit_stat = (paddr == `SDTX_OFF_STATUS);
	wire hit_count = (paddr == `SDTX_OFF_COUNT);
	wire hit_any = hit_ctrl || hit_stat || hit_count;
	wire [31:0] stat_word = {7'h00, lfsr, 7'h00, line, 3'h0, fifo_level};

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;
	assign prdata = !(psel && !pwrite) ? 32'h0000_0000 :
		hit_ctrl ? {30'h0000_0000, code_filter_n, sdi_mode} :
		hit_stat ? stat_word :
		hit_count ? {16'h0000, char_count} : 32'h0000_0000;

	// Configuration register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{code_filter_n, sdi_mode} <= `SDTX_CTRL_RESET;
		end else if (apb_wr && hit_ctrl) begin
			sdi_mode <= pwdata[`SDTX_CTRL_SDI_MODE];
			code_filter_n <= pwdata[`SDTX_CTRL_FILTER_N];
		end
	end

	// Output register; one coded character per accepted input
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			enc_q <= 10'h000;
			load_enable_out <= 1'b1;
			enc_valid <= 1'b0;
		end else if (take) begin
			enc_q <= next_q;
			load_enable_out <= next_load;
			enc_valid <= 1'b1;
		end else if (enc_ready) begin
			enc_valid <= 1'b0;
		end
	end

	// Coder state advances only on SDI characters so ASI traffic leaves it intact
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lfsr <= 9'h000;
			line <= 1'b0;
		end else if (take && sdi_mode) begin
			lfsr <= scr.lfsr;
			line <= scr.line;
		end
	end

	// Load-next request applies to the following accepted character
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			next_pending <= 1'b0;
		end else if (take) begin
			next_pending <= !sdi_mode && !fifo_char.load_next_n;
		end
	end

	// Character counter; a clear in the same cycle as a count event leaves a count of 1
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			char_count <= 16'h0000;
		end else if (apb_wr && hit_count) begin
			char_count <= take ? 16'h0001 : 16'h0000;
		end else if (take) begin
			char_count <= char_count + 16'h0001;
		end
	end
endmodule : sdtx_core

// ---- core/sdtx_fifo.sv ----
`timescale 1ns/10ps
module sdtx_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// Fill level
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_idx;
	logic [AW-1:0] rd_idx;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_idx];
	assign level = count;

	// Storage needs no reset; only the pointers and the count are control state
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_idx] <= in_data;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_idx <= '0;
			rd_idx <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
			end
			if (pop) begin
				rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
			end
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule : sdtx_fifo

// ---- include/sdtx_pkg.sv ----
package sdtx_pkg;

	// One character as the source presents it
	typedef struct packed {
		logic [9:0] data;
		logic violation_symbol_select;
		logic special_char_select;
		logic load_now_n;
		logic load_next_n;
	} sdtx_char_t;

	// Scrambler and NRZI state plus the coded character
	typedef struct packed {
		logic [8:0] lfsr;
		logic line;
		logic [9:0] q;
	} sdtx_scr_t;

endpackage : sdtx_pkg

// ---- include/sdtx_regs.svh ----
`ifndef SDTX_REGS_SVH
`define SDTX_REGS_SVH

// Register byte offsets
`define SDTX_OFF_CTRL 12'h000
`define SDTX_OFF_STATUS 12'h004
`define SDTX_OFF_COUNT 12'h008

// Control register fields and reset value
`define SDTX_CTRL_SDI_MODE 0
`define SDTX_CTRL_FILTER_N 1
`define SDTX_CTRL_RESET 2'h3

// Status register fields
`define SDTX_STAT_LEVEL_LSB 0
`define SDTX_STAT_LEVEL_MSB 4
`define SDTX_STAT_LINE 8
`define SDTX_STAT_LFSR_LSB 16
`define SDTX_STAT_LFSR_MSB 24

// Reserved timing-reference code ranges
`define SDTX_LOW_CODE_MAX 10'h003
`define SDTX_LOW_CODE 10'h000
`define SDTX_HIGH_CODE_MIN 10'h3FC
`define SDTX_HIGH_CODE 10'h3FF

// Data path sizes
`define SDTX_FIFO_DEPTH 16
`define SDTX_CHAR_BITS 10

`endif

// ---- test/sdi_tx_scrambler_controller_tb_top.sv ----
`timescale 1ns/10ps
module sdi_tx_scrambler_controller_tb_top import sdtx_pkg::*; ;
	logic core_clk, rst, psel, penable, pwrite, src_valid, stall, slow, err, prev_n, ln;
	logic pready, pslverr, src_ready, load_enable_out, enc_valid, enc_ready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0] enc_q;
	logic [8:0] st;
	logic [10:0] exp_q[$];
	sdtx_char_t src_char;
	int miscompares, num_checks, cyc;
	sdtx_core sdtx_core_inst (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .src_char, .src_valid, .src_ready, .enc_q, .load_enable_out, .enc_valid, .enc_ready);
	sdtx_serializer_model sdtx_serializer_model_inst (.core_clk, .enc_q, .load_enable_out, .enc_valid,
		.enc_ready, .stall, .slow);
	initial begin // continuous character clock
		core_clk = 1'h0;
		forever #10 core_clk = ~core_clk;
	end
	task final_report;
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] want);
		num_checks++;
		if (got !== want) begin
			miscompares++;
			$display("wrong value at %0t: %h expected %h", $time, got, want);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		// Request stands until the edge that samples pready high; data is taken at that edge
		@(posedge core_clk);
		while (!pready) @(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task push(input sdtx_char_t c);
		src_char <= c;
		src_valid <= 1'h1;
		@(negedge core_clk);
		while (!src_ready) @(negedge core_clk);
		@(posedge core_clk);
	endtask : push
	// Waits for the serializer to collect every expected character, then compares in order
	task drain;
		int n;
		n = 0;
		src_valid <= 1'h0;
		while (sdtx_serializer_model_inst.got.size() < exp_q.size() && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		while (exp_q.size() > 0) begin
			chk(32'(sdtx_serializer_model_inst.got.pop_front()), 32'(exp_q.pop_front()));
		end
		// Any leftover character means the design coded more than it was given
		chk(32'(sdtx_serializer_model_inst.got.size()), 32'h0);
	endtask : drain
	function automatic logic [10:0] sdi(input logic [9:0] d, input logic filt);
		logic [9:0] q;
		logic s;
		if (filt && d <= 10'h003) d = 10'h000;
		if (filt && d >= 10'h3FC) d = 10'h3FF;
		for (int i = 0; i < 10; i++) begin
			s = d[i] ^ st[8] ^ st[3];
			st = {st[7:0], s};
			ln = ln ^ s;
			q[i] = ln;
		end
		return {1'h0, q};
	endfunction : sdi
	function automatic logic [10:0] asi(input sdtx_char_t c);
		logic le;
		le = c.load_now_n && prev_n;
		prev_n = c.load_next_n;
		return {le, c.violation_symbol_select, c.data[7:0], c.special_char_select};
	endfunction : asi
	task t_regs;
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h3);
		apb(1'h1, 12'h00C, 32'hFFFFFFFF);
		chk({31'h0, err}, 32'h1);
		apb(1'h0, 12'h00C, 32'h0);
		chk(rd, 32'h0);
	endtask : t_regs
	task t_sdi;
		logic [9:0] v[5];
		v = '{10'h001, 10'h3FD, 10'h200, 10'h3FC, 10'h003}; // 3FC is an 8-bit FF code
		for (int f = 0; f < 2; f++) begin
			apb(1'h1, 12'h000, f ? 32'h1 : 32'h3);
			slow <= f[0];
			foreach (v[i]) begin
				push({v[i], 4'h0});
				exp_q.push_back(sdi(v[i], f[0]));
			end
			drain();
		end
		apb(1'h0, 12'h004, 32'h0);
		chk(rd, {7'h0, st, 7'h0, ln, 8'h0});
	endtask : t_sdi
	task t_asi;
		sdtx_char_t c[4];
		// 3FD would be folded by the filter; in ASI mode it must pass untouched
		c = '{{10'h0A5, 4'h9}, {10'h35A, 4'h6}, {10'h2FF, 4'hF}, {10'h3FD, 4'h3}};
		apb(1'h1, 12'h000, 32'h0);
		prev_n = 1'h1;
		foreach (c[i]) begin
			push(c[i]);
			exp_q.push_back(asi(c[i]));
		end
		drain();
	endtask : t_asi
	task t_fifo;
		stall <= 1'h1;
		apb(1'h1, 12'h008, 32'h0);
		for (int i = 0; i < 17; i++) begin
			push({10'(i), 4'h1});
			exp_q.push_back(asi({10'(i), 4'h1}));
		end
		src_valid <= 1'h0;
		@(negedge core_clk);
		chk({31'h0, src_ready}, 32'h0);
		apb(1'h0, 12'h004, 32'h0);
		chk(rd & 32'h1F, 32'h10);
		stall <= 1'h0;
		drain();
		apb(1'h0, 12'h008, 32'h0);
		chk(rd, 32'h11);
	endtask : t_fifo
	initial begin
		{rst, psel, penable, pwrite, src_valid, stall, slow, ln} = 8'h80;
		{paddr, pwdata, src_char, st} = '0;
		repeat (4) @(posedge core_clk);
		rst <= 1'h0;
		t_regs();
		t_sdi();
		t_asi();
		t_fifo();
		final_report();
	end
endmodule : sdi_tx_scrambler_controller_tb_top

// ---- test/sdtx_core_sva.sv ----
`timescale 1ns/10ps
module sdtx_core_sva (
	// Watched ports
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic src_valid,
	input wire logic src_ready,
	input wire logic [9:0] enc_q,
	input wire logic load_enable_out,
	input wire logic enc_valid,
	input wire logic enc_ready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [1:0] ctrl_seen;
	wire acc = psel && penable;
	// Shadow of the mode bits, judged without the register body
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			ctrl_seen <= 2'h3;
		else if (acc && pwrite && paddr == 12'h000)
			ctrl_seen <= pwdata[1:0];
	end
	sequence stall_s; enc_valid && !enc_ready; endsequence
	sequence take_s; src_valid && src_ready && !enc_valid; endsequence
	pready_on_a: assert property (pready) else $error("pready low");
	idle_quiet_a: assert property (!psel |-> prdata == 32'h0 && !pslverr) else $error("idle bus busy");
	unmapped_err_a: assert property (acc && paddr > 12'h008 |-> pslverr) else $error("no slave error");
	ctrl_readback_a: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[1:0] == ctrl_seen)
		else $error("mode readback");
	hold_stall_a: assert property (stall_s |=> enc_valid && $stable(enc_q) && $stable(load_enable_out))
		else $error("output moved");
	first_char_a: assert property (take_s |-> ##[1:2] enc_valid) else $error("char late");
	drop_take_a: assert property ($fell(enc_valid) |-> $past(enc_ready)) else $error("char lost");
	sdi_load_a: assert property (ctrl_seen[0] && enc_valid |-> !load_enable_out) else $error("load high");
endmodule : sdtx_core_sva
bind sdtx_core sdtx_core_sva sdtx_core_sva_inst (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .src_valid, .src_ready, .enc_q, .load_enable_out, .enc_valid, .enc_ready);

// ---- test/sdtx_serializer_model.sv ----
`timescale 1ns/10ps
module sdtx_serializer_model (
	// Coded side
	input wire logic core_clk,
	input wire logic [9:0] enc_q,
	input wire logic load_enable_out,
	input wire logic enc_valid,
	output logic enc_ready,
	// Pacing
	input wire logic stall,
	input wire logic slow
);
	logic [10:0] got[$];
	// One character per clock at most, as a fixed-rate serializer pulls
	always @(posedge core_clk) begin
		if (enc_valid && enc_ready)
			got.push_back({load_enable_out, enc_q});
		enc_ready <= !stall && !(slow && enc_ready);
	end
endmodule : sdtx_serializer_model
